// file: pkg/cap_cfg.svh
// register map, field positions, reset values and mode codes of the capture unit
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_TCTL 8'h04
`define OFF_TCNT 8'h08
`define OFF_CAPV 8'h0C
`define OFF_STAT 8'h10
`define OFF_MASK 8'h14
`define OFF_PIN  8'h18

// mode select field codes
`define MODE_OFF   4'h0
`define MODE_FALL  4'h4
`define MODE_RISE  4'h5
`define MODE_DIV4  4'h6
`define MODE_DIV16 4'h7

// field positions
`define TCTL_RUN 0
`define TCTL_EXT 1
`define PIN_DIR  0
`define PIN_LAT  1
`define PIN_ALT  2
`define STAT_CAP 0
`define CAPV_LO  0
`define CAPV_HI  8

// reset values
`define CTRL_RST 4'h0
`define TCTL_RST 2'h0
`define TCNT_RST 16'h0000
`define PIN_RST  3'h1
`define MASK_RST 1'b0

// last prescaler count before a capture fires
`define DIV4_LAST  4'h3
`define DIV16_LAST 4'hF

`endif

// file: pkg/cap_pkg.sv
// types shared by the capture unit files
package cap_pkg;
  typedef logic [31:0] word_t;
  typedef logic [15:0] count_t;
  typedef logic [3:0]  mode_t;
  typedef enum logic [1:0] {EV_FALL, EV_RISE, EV_DIV4, EV_DIV16} evsel_t;
endpackage

// file: src/bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // bit_sync

// file: src/edge_prescaler.sv
// edge qualifier and rising edge prescaler
`timescale 1ns/1ps
`include "cap_cfg.svh"
module edge_prescaler (
  // clock and reset
  input  wire logic    clk,
  input  wire logic    rst_n,
  // control
  input  wire logic    clear,
  input  cap_pkg::evsel_t sel,
  // edges in, capture out
  input  wire logic    rise,
  input  wire logic    fall,
  output logic         fire
);
  import cap_pkg::*;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // qualification per mode
  wire       div_w  = (sel == EV_DIV4) || (sel == EV_DIV16);
  wire [3:0] last_w = (sel == EV_DIV4) ? `DIV4_LAST : `DIV16_LAST;
  // >= so a switch to a shorter ratio with the count already at or past the new last fires at the next edge
  wire       hit_w  = div_w & rise & (cnt_r >= last_w);
  assign fire = (sel == EV_FALL) ? fall :
                (sel == EV_RISE) ? rise : hit_w;

  // mode switches do not touch the count, only clear does
  assign cnt_nxt = clear        ? 4'h0 :
                   hit_w        ? 4'h0 :
                   (div_w&rise) ? cnt_r + 4'h1 : cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  end

  property p_pres_clear;
    @(posedge clk) disable iff (!rst_n) clear |=> cnt_r == 4'h0;
  endproperty
  a_pres_clear: assert property (p_pres_clear)
    else $error("prescaler not cleared");

  property p_pres_hold;
    @(posedge clk) disable iff (!rst_n) (!clear && !rise) |=> $stable(cnt_r);
  endproperty
  a_pres_hold: assert property (p_pres_hold)
    else $error("prescaler count moved without an edge");

  property p_div4_fire;
    @(posedge clk) disable iff (!rst_n)
      (sel == EV_DIV4 && rise && cnt_r == 4'h3) |-> fire ##1 cnt_r == 4'h0;
  endproperty
  a_div4_fire: assert property (p_div4_fire)
    else $error("fourth rising edge did not capture");
endmodule // edge_prescaler

// file: src/timer_capture_unit.sv
// capture unit with its timer, pin logic and apb register file
`timescale 1ns/1ps
`include "cap_cfg.svh"

// Notes on behaviour
// - a qualifying event copies the whole 16-bit timer count into capture value
// - events: every falling, every rising, every 4th or every 16th rising edge
// - each capture sets the capture flag
// - a newer capture overwrites an unread capture value
// - with the pin as output, writing the port latch can cause a capture
// - changing the capture mode may raise a spurious capture flag
// - prescaler held clear while unit off or not in capture mode
// - any reset clears the prescaler
// - switching capture prescalers keeps the count and may flag spuriously
// - capture pin may be moved to an alternate pin
// - internal clock timer stops in sleep; captures in sleep need external clock
module timer_capture_unit (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  cap_pkg::word_t     pwdata,
  output cap_pkg::word_t     prdata,
  output logic               pready,
  output logic               pslverr,
  // default capture pin
  input  wire logic          cap_a_in,
  output logic               cap_a_out,
  output logic               cap_a_oe_n,
  // alternate capture pin
  input  wire logic          cap_b_in,
  output logic               cap_b_out,
  output logic               cap_b_oe_n,
  // external timer clock pin and sleep request
  input  wire logic          ext_tick_in,
  input  wire logic          sleep_req,
  // interrupt
  output logic               irq
);
  import cap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true for the four capture modes
  function automatic logic is_cap(input mode_t m);
    return (m == `MODE_FALL) || (m == `MODE_RISE) ||
           (m == `MODE_DIV4) || (m == `MODE_DIV16);
  endfunction

  // true for every mapped offset
  function automatic logic mapped(input logic [7:0] a);
    return (a == `OFF_CTRL) || (a == `OFF_TCTL) || (a == `OFF_TCNT) ||
           (a == `OFF_CAPV) || (a == `OFF_STAT) || (a == `OFF_MASK) ||
           (a == `OFF_PIN);
  endfunction

  // event kind from mode code
  function automatic evsel_t to_evsel(input mode_t m);
    case (m)
      `MODE_FALL: return EV_FALL;
      `MODE_RISE: return EV_RISE;
      `MODE_DIV4: return EV_DIV4;
      default:    return EV_DIV16;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  mode_t       ctrl_r;
  logic [1:0]  tctl_r;
  count_t      timer_r;
  count_t      timer_nxt;
  count_t      cap_val_r;
  logic        flag_r;
  logic        flag_nxt;
  logic        ie_r;
  logic [2:0]  pin_r;
  word_t       prdata_r;
  logic        pin_prev_r;
  logic        ext_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup_w = psel & ~penable;
  wire acc_w   = psel & penable;
  wire wr_w    = acc_w & pwrite & mapped(paddr);
  wire wr_ctrl = wr_w & (paddr == `OFF_CTRL);
  wire wr_tctl = wr_w & (paddr == `OFF_TCTL);
  wire wr_tcnt = wr_w & (paddr == `OFF_TCNT);
  wire wr_stat = wr_w & (paddr == `OFF_STAT);
  wire wr_mask = wr_w & (paddr == `OFF_MASK);
  wire wr_pin  = wr_w & (paddr == `OFF_PIN);

  // zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc_w & ~mapped(paddr);
  assign prdata  = prdata_r;

  // read selection
  wire [15:0] cap_word_w = {cap_val_r[15:`CAPV_HI], cap_val_r[`CAPV_HI-1:`CAPV_LO]};
  wire word_t rd_w =
    (paddr == `OFF_CTRL) ? {28'h000_0000, ctrl_r} :
    (paddr == `OFF_TCTL) ? {30'h0000_0000, tctl_r} :
    (paddr == `OFF_TCNT) ? {16'h0000, timer_r} :
    (paddr == `OFF_CAPV) ? {16'h0000, cap_word_w} :
    (paddr == `OFF_STAT) ? {31'h0000_0000, flag_r} :
    (paddr == `OFF_MASK) ? {31'h0000_0000, ie_r} :
    (paddr == `OFF_PIN)  ? {29'h0000_0000, pin_r} : 32'h0000_0000;

  // read data is captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_r <= 32'h0000_0000;
    else if (setup_w && !pwrite) prdata_r <= rd_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin routing and synchronisers

  logic [1:0] pins_s;
  logic       ext_s;

  bit_sync #(.W(2)) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({cap_b_in, cap_a_in}),
    .q     (pins_s)
  );

  bit_sync #(.W(1)) u_ext_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ext_tick_in),
    .q     (ext_s)
  );

  // the pin function sits on one pin at a time
  wire alt_w  = pin_r[`PIN_ALT];
  wire pin_s  = alt_w ? pins_s[1] : pins_s[0];
  wire drv_w  = ~pin_r[`PIN_DIR];

  // an output pin reads back its own level, so a latch write is an edge
  assign cap_a_oe_n = alt_w | ~drv_w;
  assign cap_b_oe_n = ~alt_w | ~drv_w;
  assign cap_a_out  = pin_r[`PIN_LAT];
  assign cap_b_out  = pin_r[`PIN_LAT];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and qualification

  wire cap_en_w = is_cap(ctrl_r);
  // in sleep an internally clocked timer is frozen, so captures stop too
  wire sleep_blk = sleep_req & ~tctl_r[`TCTL_EXT];
  wire gate_w    = cap_en_w & ~sleep_blk;
  wire rise_w    = pin_s & ~pin_prev_r & gate_w;
  wire fall_w    = ~pin_s & pin_prev_r & gate_w;
  wire fire_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_s;
      ext_prev_r <= ext_s;
    end
  end

  edge_prescaler u_pres (
    .clk   (pclk),
    .rst_n (presetn),
    .clear (~cap_en_w),
    .sel   (to_evsel(ctrl_r)),
    .rise  (rise_w),
    .fall  (fall_w),
    .fire  (fire_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sixteen-bit timer

  wire ext_rise = ext_s & ~ext_prev_r;
  // internal tick pauses in sleep and resumes from the held count
  wire tick_w = tctl_r[`TCTL_RUN] &
                (tctl_r[`TCTL_EXT] ? ext_rise : ~sleep_req);
  assign timer_nxt = wr_tcnt ? pwdata[15:0] : timer_r + {15'h0000, tick_w};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_r <= `TCNT_RST;
    else timer_r <= timer_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture and flag

  // a hop between two capture modes keeps the count and flags spuriously
  wire spur_w = wr_ctrl & (pwdata[3:0] != ctrl_r) &
                is_cap(pwdata[3:0]) & cap_en_w;

  // set wins over the write-one clear
  assign flag_nxt = fire_w | spur_w |
                    (flag_r & ~(wr_stat & pwdata[`STAT_CAP]));

  // whole count taken in one edge; an unread value is simply replaced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cap_val_r <= 16'h0000;
    else if (fire_w) cap_val_r <= timer_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_r <= 1'b0;
    else flag_r <= flag_nxt;
  end

  assign irq = flag_r & ie_r;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RST;
      tctl_r <= `TCTL_RST;
      ie_r   <= `MASK_RST;
      pin_r  <= `PIN_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= pwdata[3:0];
      if (wr_tctl) tctl_r <= pwdata[1:0];
      if (wr_mask) ie_r <= pwdata[0];
      if (wr_pin) pin_r <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_mode_hop;
    spur_w ##1 flag_r;
  endsequence

  property p_copy;
    fire_w |=> cap_val_r == $past(timer_r);
  endproperty
  a_copy: assert property (p_copy)
    else $error("capture value differs from timer count");

  property p_fall_mode;
    (ctrl_r == `MODE_FALL && fall_w) |-> fire_w;
  endproperty
  a_fall_mode: assert property (p_fall_mode)
    else $error("falling edge not captured");

  property p_flag_set;
    fire_w |=> flag_r && irq == ie_r;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("capture did not set flag");

  property p_overwrite;
    (fire_w && flag_r) |=> cap_val_r == $past(timer_r) && flag_r;
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("newer capture did not overwrite");

  property p_drive;
    (!pin_r[`PIN_DIR] && !pin_r[`PIN_ALT]) |-> !cap_a_oe_n && cap_b_oe_n;
  endproperty
  a_drive: assert property (p_drive)
    else $error("output pin not driven");

  property p_spur;
    spur_w |-> s_mode_hop;
  endproperty
  a_spur: assert property (p_spur)
    else $error("mode hop without flag");

  property p_off_quiet;
    !cap_en_w |-> !fire_w;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("capture while unit off");

  property p_alt;
    pin_r[`PIN_ALT] |-> cap_a_oe_n;
  endproperty
  a_alt: assert property (p_alt)
    else $error("default pin driven while relocated");

  property p_sleep;
    (sleep_req && !tctl_r[`TCTL_EXT] && !wr_tcnt) |=> $stable(timer_r) && !$past(fire_w);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("timer moved in sleep");

  property p_sync;
    (ctrl_r == `MODE_RISE && !sleep_blk && $rose(pin_s)) |-> fire_w;
  endproperty
  a_sync: assert property (p_sync)
    else $error("synced rising edge not captured");

  // flag and capture value only move for their own causes
  property p_cap_hold;
    !fire_w |=> $stable(cap_val_r);
  endproperty
  a_cap_hold: assert property (p_cap_hold)
    else $error("capture value moved without a capture");

  property p_flag_hold;
    (flag_r && !(wr_stat && pwdata[`STAT_CAP])) |=> flag_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("capture flag dropped without a clear");

  property p_flag_clear;
    (wr_stat && pwdata[`STAT_CAP] && !fire_w && !spur_w) |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("write of one did not clear the flag");

  property p_rise_mode;
    (ctrl_r == `MODE_RISE && rise_w) |-> fire_w;
  endproperty
  a_rise_mode: assert property (p_rise_mode)
    else $error("rising edge not captured");

  // with an external clock the timer keeps counting through sleep
  property p_ext_count;
    (tctl_r[`TCTL_RUN] && tctl_r[`TCTL_EXT] && ext_rise && !wr_tcnt) |=>
      timer_r == $past(timer_r) + 16'h0001;
  endproperty
  a_ext_count: assert property (p_ext_count)
    else $error("external tick did not advance the timer");
endmodule // timer_capture_unit

// file: verif/pin_source.sv
// behavioural source of edges on one capture pin
`timescale 1ns/1ps
module pin_source (
  // clock
  input  wire logic pclk,
  // unit side of the pin
  input  wire logic oe_n,
  input  wire logic lat,
  // resolved pin level
  output logic      pin
);
  logic drv;

  initial drv = 1'b0;

  // the unit owns the pin only while its enable is low
  assign pin = oe_n ? drv : lat;

  ////////////////////////////////////////////////////////////////////////////
  // slow levels: four cycles either side so the synchroniser sees each one
  task automatic lvl(input logic v);
    repeat (4) @(posedge pclk);
    drv <= v;
    repeat (4) @(posedge pclk);
  endtask

  // n rising edges, each followed by a falling edge
  task automatic pulse(input int n);
    repeat (n) begin
      lvl(1'b1);
      lvl(1'b0);
    end
  endtask
endmodule // pin_source

// file: verif/tb_top.sv
// self-checking bench of the capture unit
`timescale 1ns/1ps
`include "cap_cfg.svh"
module tb_top;
  import cap_pkg::*;
  logic       pclk, presetn, psel, penable, pwrite, sleep_req, ext_tick;
  logic [7:0] paddr;
  word_t      pwdata, prdata;
  logic       pready, pslverr, irq;
  logic       a_out, a_oe_n, b_out, b_oe_n;
  wire        pin_a, pin_b;
  int         n_mismatch, comparisons, cyc;
  word_t      v;
  logic       e;

  timer_capture_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_a_in(pin_a),
    .cap_a_out(a_out), .cap_a_oe_n(a_oe_n), .cap_b_in(pin_b),
    .cap_b_out(b_out), .cap_b_oe_n(b_oe_n), .ext_tick_in(ext_tick),
    .sleep_req(sleep_req), .irq(irq));
  pin_source u_pa (.pclk(pclk), .oe_n(a_oe_n), .lat(a_out), .pin(pin_a));
  pin_source u_pb (.pclk(pclk), .oe_n(b_oe_n), .lat(b_out), .pin(pin_b));

  always #2 pclk = ~pclk;

  // hang guard, some twenty-five times the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // apb transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input word_t d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input word_t d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input word_t exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(v, exp);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // off, new mode, stopped timer loaded, stale flag cleared
  task automatic prep(input mode_t m, input logic [15:0] tv);
    wr(`OFF_CTRL, 32'h0000_0000);
    wr(`OFF_TCTL, 32'h0000_0000);
    wr(`OFF_CTRL, {28'h000_0000, m});
    wr(`OFF_TCNT, {16'h0000, tv});
    wr(`OFF_STAT, 32'h0000_0001);
  endtask

  task automatic expect_cap(input logic f, input logic [15:0] tv);
    repeat (4) @(posedge pclk);
    rd_chk(`OFF_STAT, {31'h0, f});
    if (f) rd_chk(`OFF_CAPV, {16'h0000, tv});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(`OFF_PIN, 32'h0000_0001);
    rd_chk(`OFF_CTRL, 32'h0000_0000);
    rd_chk(`OFF_MASK, 32'h0000_0000);
    rd_chk(`OFF_STAT, 32'h0000_0000);
    chk({30'h0, a_oe_n, b_oe_n}, 32'h0000_0003);
    rd_chk(8'h1C, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
  endtask

  task automatic t_rise();
    prep(`MODE_RISE, 16'h1234);
    wr(`OFF_MASK, 32'h0000_0001);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'h1234);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`OFF_TCNT, 32'h0000_BEEF);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'hBEEF);
    wr(`OFF_STAT, 32'h0000_0001);
    expect_cap(1'b0, 16'h0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`OFF_MASK, 32'h0000_0000);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'hBEEF);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask

  task automatic t_fall();
    prep(`MODE_FALL, 16'h00F0);
    u_pa.lvl(1'b1);
    expect_cap(1'b0, 16'h0000);
    u_pa.lvl(1'b0);
    expect_cap(1'b1, 16'h00F0);
  endtask

  task automatic t_div();
    prep(`MODE_DIV4, 16'h0444);
    u_pa.pulse(3);
    expect_cap(1'b0, 16'h0000);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'h0444);
    prep(`MODE_DIV16, 16'h1616);
    u_pa.pulse(15);
    expect_cap(1'b0, 16'h0000);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'h1616);
    prep(`MODE_DIV4, 16'h0011);
    u_pa.pulse(2);
    prep(`MODE_DIV4, 16'h0011);
    u_pa.pulse(3);
    expect_cap(1'b0, 16'h0000);
    // count left at three so the reset has something to clear
    do_reset();
    prep(`MODE_DIV4, 16'h0012);
    u_pa.pulse(3);
    expect_cap(1'b0, 16'h0000);
  endtask

  // direct switch between prescalers keeps the count
  task automatic t_switch();
    prep(`MODE_DIV16, 16'h0777);
    u_pa.pulse(2);
    wr(`OFF_CTRL, {28'h000_0000, `MODE_DIV4});
    expect_cap(1'b1, 16'h0000);
    wr(`OFF_STAT, 32'h0000_0001);
    u_pa.pulse(1);
    expect_cap(1'b0, 16'h0000);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'h0777);
  endtask

  task automatic t_portw();
    prep(`MODE_RISE, 16'h5A5A);
    wr(`OFF_PIN, 32'h0000_0000);
    @(posedge pclk);
    chk({31'h0, a_oe_n}, 32'h0000_0000);
    expect_cap(1'b0, 16'h0000);
    wr(`OFF_PIN, 32'h0000_0002);
    expect_cap(1'b1, 16'h5A5A);
    chk({30'h0, a_out, b_out}, 32'h0000_0003);
    wr(`OFF_PIN, 32'h0000_0001);
  endtask

  task automatic t_alt();
    prep(`MODE_RISE, 16'h0ABC);
    wr(`OFF_PIN, 32'h0000_0005);
    u_pa.pulse(1);
    expect_cap(1'b0, 16'h0000);
    u_pb.pulse(1);
    expect_cap(1'b1, 16'h0ABC);
    wr(`OFF_PIN, 32'h0000_0001);
  endtask

  task automatic t_sleep();
    prep(`MODE_RISE, 16'h0100);
    sleep_req <= 1'b1;
    wr(`OFF_TCTL, 32'h0000_0001);
    u_pa.pulse(1);
    expect_cap(1'b0, 16'h0000);
    rd_chk(`OFF_TCNT, 32'h0000_0100);
    sleep_req <= 1'b0;
    repeat (10) @(posedge pclk);
    xfer(1'b0, `OFF_TCNT, 32'h0000_0000);
    chk({31'h0, v > 32'h0000_0100}, 32'h0000_0001);
  endtask

  // n slow rising edges on the external timer clock pin
  task automatic ext_pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge pclk);
      ext_tick <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_tick <= 1'b0;
    end
  endtask

  // external timer clock keeps counting and capturing through sleep
  task automatic t_ext();
    prep(`MODE_RISE, 16'h0200);
    wr(`OFF_TCTL, 32'h0000_0003);
    sleep_req <= 1'b1;
    ext_pulse(5);
    rd_chk(`OFF_TCNT, 32'h0000_0205);
    u_pa.pulse(1);
    expect_cap(1'b1, 16'h0205);
    sleep_req <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; sleep_req = 1'b0;
    ext_tick = 1'b0;
    n_mismatch = 0; comparisons = 0; cyc = 0;
    do_reset();
    t_reset();
    t_rise();
    t_fall();
    t_div();
    t_switch();
    t_portw();
    t_alt();
    t_sleep();
    t_ext();
    wrap_up();
  end
endmodule // tb_top
